// ===== logic/rlf_defs.vh
// Constants for the redundant link failover controller
// Operation
// - Up to 18 pairs, each with its own configuration and state, chosen by index.
// - Each pair names a primary and a secondary port as hub plus port.
// - Normally the primary carries traffic and the secondary stays inactive.
// - A failed primary makes the controller activate the secondary instead.
// - After switchover the secondary stays active; no automatic fallback.
// - Failure declared only after link stays down for more than 5 seconds.
// - Switchover notifies only when the pair's notify setting is on.
// - Each pair reports its active port: primary, secondary or both failed.
// - A failing active secondary gives both-failed until status is enabled again or return-to-primary is given.
// - An enabled pair runs primary active, secondary disabled.
// - Primary disabled suspends the pair; re-enabling it restores enabled.
// - Secondary disabled suspends with both ports off; re-enabling restores normal.
// - Disabling or suspending a pair never switches its ports over.
// - Return-to-primary makes the primary the active port again.
// - Return-to-primary notifies on enabled pairs, silently reactivates suspended ones.
// - A saved configuration change takes effect at once.
// - Link is up while pulses arrive; with link test off it reads up.
`ifndef RLF_DEFS_VH
`define RLF_DEFS_VH
`define RLF_PAIRS 18
`define RLF_PAIR_BASE 5'h01
`define RLF_HUBS 3'h6
`define RLF_HUB_PORTS 8'h18
`define RLF_PORTS 144
`define RLF_PORT_LIMIT 8'h90
`define RLF_CLK_NS 8
`define RLF_TICK_MS 1
`define RLF_FAIL_TIME_MS 5000
`define RLF_TICK_CYCLES 24'h01e848
`define RLF_FAIL_TICKS 16'h1388
`define RLF_ST_DIS 2'h0
`define RLF_ST_EN 2'h1
`define RLF_ST_SUSP 2'h2
`define RLF_ACT_PRI 2'h0
`define RLF_ACT_SEC 2'h1
`define RLF_ACT_BOTH 2'h2
`define RLF_KIND_SWITCH 1'b0
`define RLF_KIND_RETURN 1'b1
`endif

// ===== logic/redundant_link_failover.v
// Redundant link pair failover controller
`include "rlf_defs.vh"
module redundant_link_failover #(
    parameter [23:0] TICK_CYCLES = `RLF_TICK_CYCLES,
    parameter [15:0] FAIL_TICKS = `RLF_FAIL_TICKS
) (
    input wire ref_clk_in, // System clock
    input wire rst_in, // Async reset, high
    input wire cfg_wr_in, // Save pulse for one pair
    input wire [4:0] cfg_idx_in, // Pair index 1..18
    input wire [2:0] cfg_pri_hub_in, // Primary hub 1..6
    input wire [4:0] cfg_pri_port_in, // Primary port 1..24
    input wire [2:0] cfg_sec_hub_in, // Secondary hub 1..6
    input wire [4:0] cfg_sec_port_in, // Secondary port 1..24
    input wire cfg_notify_in, // Switchover notify enable
    input wire [1:0] cfg_status_in, // Pair status
    input wire ret_pri_in, // Return-to-primary pulse
    input wire [4:0] ret_idx_in, // Pair index 1..18
    input wire [143:0] link_up_in, // Link pulses seen, per port
    input wire [143:0] link_test_in, // Link test enabled, per port
    input wire [143:0] port_admin_in, // Port enabled by port control
    output wire [143:0] port_active_out, // Port may carry traffic
    output wire [35:0] pair_status_out, // 2 bits per pair
    output wire [35:0] pair_active_out, // 2 bits per pair
    output reg notify_out, // Notification pulse
    output reg [4:0] notify_idx_out, // Pair of the notification
    output reg notify_kind_out // 0 switchover, 1 return
);

    integer i;
    integer k;
    integer j;
    reg [143:0] link_m_r;
    reg [143:0] link_s_r;
    reg [143:0] test_m_r;
    reg [143:0] test_s_r;
    reg [143:0] adm_m_r;
    reg [143:0] adm_s_r;
    reg [143:0] port_act_r;
    reg [2:0] pri_hub_r [0:17];
    reg [4:0] pri_port_r [0:17];
    reg [2:0] sec_hub_r [0:17];
    reg [4:0] sec_port_r [0:17];
    reg [15:0] tmr_r [0:17];
    reg [17:0] ntf_en_r;
    reg [17:0] susp_sec_r;
    reg [17:0] pend_r;
    reg [17:0] kind_r;
    reg [35:0] status_r;
    reg [35:0] active_r;
    reg [23:0] tick_cnt_r;
    reg tick_r;
    reg [143:0] ctl_c;
    reg [17:0] pri_up_c;
    reg [17:0] sec_up_c;
    reg [17:0] pri_adm_c;
    reg [17:0] sec_adm_c;
    reg [17:0] grant_c;
    reg [4:0] grant_idx_c;
    reg [7:0] pi_c;
    reg [7:0] si_c;
    reg [1:0] st_c;
    reg [1:0] ac_c;
    reg [17:0] up_c;
    reg [17:0] en_c;
    reg [17:0] susp_c;
    reg [17:0] apri_c;
    reg [17:0] aboth_c;
    // Suspend ordered by management, as opposed to one caused by port control
    reg [17:0] susp_mgmt_r;
    wire [143:0] link_eff;

    // Flat port index from hub and port numbers; out of range gives the limit
    function [7:0] port_index;
        input [2:0] hub;
        input [4:0] port;
        reg [7:0] h;
        reg [7:0] p;
        begin
            h = {5'h00, hub} - 8'h01;
            p = {3'h0, port} - 8'h01;
            if (hub == 3'h0 || hub > `RLF_HUBS || port == 5'h00 ||
                p >= `RLF_HUB_PORTS) begin
                port_index = `RLF_PORT_LIMIT;
            end else begin
                port_index = h * `RLF_HUB_PORTS + p;
            end
        end
    endfunction

    // Bit of a port vector; unmapped ports read as the fill value
    function bit_at;
        input [143:0] vec;
        input [7:0] idx;
        input fill;
        begin
            if (idx < `RLF_PORT_LIMIT) begin
                bit_at = vec[idx];
            end else begin
                bit_at = fill;
            end
        end
    endfunction

    // A port with link test off always reads link up
    assign link_eff = link_s_r | ~test_s_r;

    assign port_active_out = port_act_r;
    assign pair_status_out = status_r;
    assign pair_active_out = active_r;

    // Per-pair view of the ports, and the port control each pair imposes
    always @* begin
        ctl_c = {`RLF_PORTS{1'b1}};
        pri_up_c = 18'h00000;
        sec_up_c = 18'h00000;
        pri_adm_c = 18'h00000;
        sec_adm_c = 18'h00000;
        up_c = 18'h00000;
        en_c = 18'h00000;
        susp_c = 18'h00000;
        apri_c = 18'h00000;
        aboth_c = 18'h00000;
        pi_c = 8'h00;
        si_c = 8'h00;
        st_c = 2'h0;
        ac_c = 2'h0;
        for (k = 0; k < `RLF_PAIRS; k = k + 1) begin
            pi_c = port_index(pri_hub_r[k], pri_port_r[k]);
            si_c = port_index(sec_hub_r[k], sec_port_r[k]);
            st_c = status_r[2*k +: 2];
            ac_c = active_r[2*k +: 2];
            pri_up_c[k] = bit_at(link_eff, pi_c, 1'b1);
            sec_up_c[k] = bit_at(link_eff, si_c, 1'b1);
            pri_adm_c[k] = bit_at(adm_s_r, pi_c, 1'b1);
            sec_adm_c[k] = bit_at(adm_s_r, si_c, 1'b1);
            // Decoded pair state for the sequential logic
            en_c[k] = (st_c == `RLF_ST_EN);
            susp_c[k] = (st_c == `RLF_ST_SUSP);
            apri_c[k] = (ac_c == `RLF_ACT_PRI);
            aboth_c[k] = (ac_c == `RLF_ACT_BOTH);
            up_c[k] = apri_c[k] ? pri_up_c[k] : sec_up_c[k];
            if (st_c == `RLF_ST_EN) begin
                // Only one port of the pair passes traffic, so no loop forms
                if (pi_c < `RLF_PORT_LIMIT) begin
                    ctl_c[pi_c] = (ac_c == `RLF_ACT_PRI);
                end
                if (si_c < `RLF_PORT_LIMIT) begin
                    ctl_c[si_c] = (ac_c != `RLF_ACT_PRI);
                end
            end else if (st_c == `RLF_ST_SUSP) begin
                if (pi_c < `RLF_PORT_LIMIT) begin
                    ctl_c[pi_c] = 1'b0;
                end
                if (si_c < `RLF_PORT_LIMIT) begin
                    ctl_c[si_c] = 1'b0;
                end
            end
        end
    end

    // Lowest pending pair wins the single notification output
    always @* begin
        grant_c = 18'h00000;
        grant_idx_c = 5'h00;
        for (j = `RLF_PAIRS - 1; j >= 0; j = j - 1) begin
            if (pend_r[j]) begin
                grant_c = 18'h00000;
                grant_c[j] = 1'b1;
                grant_idx_c = j[4:0] + `RLF_PAIR_BASE;
            end
        end
    end

    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link_m_r <= {`RLF_PORTS{1'b0}};
            link_s_r <= {`RLF_PORTS{1'b0}};
            test_m_r <= {`RLF_PORTS{1'b0}};
            test_s_r <= {`RLF_PORTS{1'b0}};
            adm_m_r <= {`RLF_PORTS{1'b0}};
            adm_s_r <= {`RLF_PORTS{1'b0}};
            port_act_r <= {`RLF_PORTS{1'b0}};
            tick_cnt_r <= 24'h000000;
            tick_r <= 1'b0;
            ntf_en_r <= 18'h00000;
            susp_sec_r <= 18'h00000;
            susp_mgmt_r <= 18'h00000;
            pend_r <= 18'h00000;
            kind_r <= 18'h00000;
            status_r <= 36'h000000000;
            active_r <= 36'h000000000;
            notify_out <= 1'b0;
            notify_idx_out <= 5'h00;
            notify_kind_out <= 1'b0;
            for (i = 0; i < `RLF_PAIRS; i = i + 1) begin
                pri_hub_r[i] <= 3'h0;
                pri_port_r[i] <= 5'h00;
                sec_hub_r[i] <= 3'h0;
                sec_port_r[i] <= 5'h00;
                tmr_r[i] <= 16'h0000;
            end
        end else begin
            link_m_r <= link_up_in;
            link_s_r <= link_m_r;
            test_m_r <= link_test_in;
            test_s_r <= test_m_r;
            adm_m_r <= port_admin_in;
            adm_s_r <= adm_m_r;
            port_act_r <= ctl_c & adm_s_r;
            // Shared prescaler keeps each pair's timer narrow
            if (tick_cnt_r >= TICK_CYCLES - 24'h000001) begin
                tick_cnt_r <= 24'h000000;
                tick_r <= 1'b1;
            end else begin
                tick_cnt_r <= tick_cnt_r + 24'h000001;
                tick_r <= 1'b0;
            end
            notify_out <= |pend_r;
            notify_idx_out <= grant_idx_c;
            notify_kind_out <= |(kind_r & grant_c);
            for (i = 0; i < `RLF_PAIRS; i = i + 1) begin
                if (grant_c[i]) begin
                    pend_r[i] <= 1'b0;
                end
                if (cfg_wr_in && (cfg_idx_in - `RLF_PAIR_BASE) == i[4:0]) begin
                    // Saved settings take effect from the next cycle
                    pri_hub_r[i] <= cfg_pri_hub_in;
                    pri_port_r[i] <= cfg_pri_port_in;
                    sec_hub_r[i] <= cfg_sec_hub_in;
                    sec_port_r[i] <= cfg_sec_port_in;
                    ntf_en_r[i] <= cfg_notify_in;
                    susp_sec_r[i] <= 1'b0;
                    susp_mgmt_r[i] <= (cfg_status_in == `RLF_ST_SUSP);
                    tmr_r[i] <= 16'h0000;
                    if (cfg_status_in == `RLF_ST_EN) begin
                        status_r[2*i +: 2] <= `RLF_ST_EN;
                        active_r[2*i +: 2] <= `RLF_ACT_PRI;
                    end else if (cfg_status_in == `RLF_ST_SUSP) begin
                        status_r[2*i +: 2] <= `RLF_ST_SUSP;
                    end else begin
                        status_r[2*i +: 2] <= `RLF_ST_DIS;
                    end
                end else if (ret_pri_in && (ret_idx_in - `RLF_PAIR_BASE) == i[4:0] &&
                             (en_c[i] || susp_c[i])) begin
                    active_r[2*i +: 2] <= `RLF_ACT_PRI;
                    status_r[2*i +: 2] <= `RLF_ST_EN;
                    susp_sec_r[i] <= 1'b0;
                    // Return also lifts a suspend that management ordered
                    susp_mgmt_r[i] <= 1'b0;
                    tmr_r[i] <= 16'h0000;
                    if (en_c[i]) begin
                        pend_r[i] <= 1'b1;
                        kind_r[i] <= `RLF_KIND_RETURN;
                    end
                end else if (en_c[i] && !pri_adm_c[i]) begin
                    status_r[2*i +: 2] <= `RLF_ST_SUSP;
                    susp_sec_r[i] <= 1'b0;
                    susp_mgmt_r[i] <= 1'b0;
                    tmr_r[i] <= 16'h0000;
                end else if (en_c[i] && !sec_adm_c[i]) begin
                    status_r[2*i +: 2] <= `RLF_ST_SUSP;
                    susp_sec_r[i] <= 1'b1;
                    susp_mgmt_r[i] <= 1'b0;
                    tmr_r[i] <= 16'h0000;
                end else if (susp_c[i]) begin
                    // Resume needs both ports back; the active port is kept unless a disabled secondary caused the suspend.
                    // A suspend set by management waits for management instead.
                    if (!susp_mgmt_r[i] && pri_adm_c[i] && sec_adm_c[i]) begin
                        status_r[2*i +: 2] <= `RLF_ST_EN;
                        susp_sec_r[i] <= 1'b0;
                        if (susp_sec_r[i]) begin
                            active_r[2*i +: 2] <= `RLF_ACT_PRI;
                        end
                    end
                end else if (en_c[i] && !aboth_c[i]) begin
                    // A recovered primary does not pull the pair back
                    if (up_c[i]) begin
                        tmr_r[i] <= 16'h0000;
                    end else if (tick_r) begin
                        if (tmr_r[i] >= FAIL_TICKS) begin
                            tmr_r[i] <= 16'h0000;
                            if (apri_c[i]) begin
                                active_r[2*i +: 2] <= `RLF_ACT_SEC;
                                if (ntf_en_r[i]) begin
                                    pend_r[i] <= 1'b1;
                                    kind_r[i] <= `RLF_KIND_SWITCH;
                                end
                            end else begin
                                active_r[2*i +: 2] <= `RLF_ACT_BOTH;
                            end
                        end else begin
                            tmr_r[i] <= tmr_r[i] + 16'h0001;
                        end
                    end
                end
            end
        end
    end

    // Link testing on both ports is the management side's duty; an untested
    // port reads up forever and so can never fail over

endmodule

// ===== dv/rlf_checker.sv
// Concurrent checks on pair 1 of the failover controller
module rlf_checker #(
    parameter [23:0] TICK_CYCLES = 24'h000004,
    parameter [15:0] FAIL_TICKS = 16'h0003
) (
    input logic ref_clk_in, // Clock
    input logic rst_in, // Reset
    input logic cfg_wr_in, // Save
    input logic [4:0] cfg_idx_in, // Saved pair
    input logic cfg_notify_in, // Notify enable
    input logic [1:0] cfg_status_in, // Saved status
    input logic ret_pri_in, // Return
    input logic [4:0] ret_idx_in, // Returned pair
    input logic [143:0] link_up_in, // Links
    input logic [143:0] port_active_out, // Port drive
    input logic [35:0] pair_status_out, // Status
    input logic [35:0] pair_active_out, // Active port
    input logic notify_out, // Event
    input logic [4:0] notify_idx_out, // Event pair
    input logic notify_kind_out // Event kind
);
    timeunit 1ns;
    timeprecision 1ps;
    // The bench keeps pair 1 on bits 0 and 1, so those bits stand for its ports
    localparam int LIM = (FAIL_TICKS + 2) * TICK_CYCLES + 6;
    wire [1:0] st = pair_status_out[1:0];
    wire [1:0] ac = pair_active_out[1:0];
    wire w1 = cfg_wr_in && cfg_idx_in == 5'h01;
    wire r1 = ret_pri_in && ret_idx_in == 5'h01 && !w1;
    wire n1 = notify_out && notify_idx_out == 5'h01;
    wire run = st == 2'h1 && ac == 2'h0 && !link_up_in[0] && !w1;
    logic [15:0] dn_r;
    logic [15:0] run_r;
    logic nen_r;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dn_r <= 16'h0000;
            run_r <= 16'h0000;
            nen_r <= 1'b0;
        end else begin
            dn_r <= link_up_in[0] ? 16'h0000 : dn_r + 16'h0001;
            run_r <= run ? run_r + 16'h0001 : 16'h0000;
            nen_r <= w1 ? cfg_notify_in : nen_r;
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    a_cfg_apply: assert property (w1 && cfg_status_in == 2'h1 |=> st == 2'h1 && ac == 2'h0)
        else $error("saved config not applied");
    a_idle_backup: assert property ($past(st) == 2'h1 && $past(ac) == 2'h0 |-> !port_active_out[1])
        else $error("backup port driven");
    a_susp_off: assert property ($past(st) == 2'h2 |-> port_active_out[1:0] == 2'h0)
        else $error("suspended pair drives a port");
    a_no_fallback: assert property ($past(ac) != 2'h0 && ac == 2'h0
        |-> $past(w1 || r1 || st == 2'h2)) else $error("active port fell back");
    a_no_early: assert property ($past(ac) == 2'h0 && ac == 2'h1
        |-> dn_r >= FAIL_TICKS * TICK_CYCLES) else $error("switch too early");
    a_switch_bound: assert property (run_r <= LIM) else $error("switch too late");
    a_no_idle_switch: assert property ($past(ac) == 2'h0 && ac == 2'h1 |-> $past(st) == 2'h1)
        else $error("switch while not enabled");
    a_switch_notify: assert property ($past(ac) == 2'h0 && ac == 2'h1
        |=> (n1 && !notify_kind_out) == nen_r) else $error("switch event wrong");
    a_ret_apply: assert property (r1 && st inside {2'h1, 2'h2} |=> st == 2'h1 && ac == 2'h0)
        else $error("return not applied");
    a_ret_notify: assert property (r1 && st == 2'h1 |-> ##2 n1 && notify_kind_out)
        else $error("return event missing");
    a_susp_silent: assert property (r1 && st == 2'h2 |-> ##2 !n1)
        else $error("suspended return notified");
endmodule
bind redundant_link_failover rlf_checker #(.TICK_CYCLES(TICK_CYCLES), .FAIL_TICKS(FAIL_TICKS))
    i_rlf_checker (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr_in),
    .cfg_idx_in(cfg_idx_in), .cfg_notify_in(cfg_notify_in), .cfg_status_in(cfg_status_in),
    .ret_pri_in(ret_pri_in), .ret_idx_in(ret_idx_in), .link_up_in(link_up_in),
    .port_active_out(port_active_out), .pair_status_out(pair_status_out),
    .pair_active_out(pair_active_out), .notify_out(notify_out),
    .notify_idx_out(notify_idx_out), .notify_kind_out(notify_kind_out));

// ===== dv/port_link_model.sv
// Model of the repeater port link, link test and admin logic
module port_link_model (
    input logic ref_clk_in, // Clock
    input logic rst_in, // Reset
    input logic [143:0] drop_in, // Link pulses stop
    input logic [143:0] untest_in, // Link test off
    input logic [143:0] off_in, // Port disabled
    output logic [143:0] link_up_out, // Link seen
    output logic [143:0] link_test_out, // Test enabled
    output logic [143:0] port_admin_out // Admin enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // Link test is only turned off where a scenario asks for it
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link_up_out <= '1;
            link_test_out <= '1;
            port_admin_out <= '1;
        end else begin
            link_up_out <= ~drop_in;
            link_test_out <= ~untest_in;
            port_admin_out <= ~off_in;
        end
    end
endmodule

// ===== dv/redundant_link_failover_tb.sv
// Self-checking bench for the failover controller
module redundant_link_failover_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 4;
    localparam int FT = 3;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cfg_wr = 1'b0;
    logic ret = 1'b0;
    logic [4:0] ret_idx = 5'h00;
    logic [23:0] cv = 24'h000000; // Index, primary, secondary, notify, status
    logic [143:0] drop = '0;
    logic [143:0] untest = '0;
    logic [143:0] off = '0;
    wire [143:0] link_up, link_test, admin, port_act;
    wire [35:0] pst, pact;
    wire nfy, nkind;
    wire [4:0] nidx;
    int err_count = 0;
    int cmp_count = 0;
    int ncnt = 0;
    logic [5:0] nlast = 6'h00;
    int n;
    int i;
    logic [35:0] snap;
    initial forever #4 ref_clk_in = ~ref_clk_in;
    port_link_model i_port_link_model (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .drop_in(drop), .untest_in(untest), .off_in(off), .link_up_out(link_up),
        .link_test_out(link_test), .port_admin_out(admin));
    redundant_link_failover #(.TICK_CYCLES(24'h000004), .FAIL_TICKS(16'h0003))
        i_redundant_link_failover (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .cfg_wr_in(cfg_wr), .cfg_idx_in(cv[23:19]), .cfg_pri_hub_in(cv[18:16]),
        .cfg_pri_port_in(cv[15:11]), .cfg_sec_hub_in(cv[10:8]), .cfg_sec_port_in(cv[7:3]),
        .cfg_notify_in(cv[2]), .cfg_status_in(cv[1:0]), .ret_pri_in(ret),
        .ret_idx_in(ret_idx), .link_up_in(link_up), .link_test_in(link_test),
        .port_admin_in(admin), .port_active_out(port_act), .pair_status_out(pst),
        .pair_active_out(pact), .notify_out(nfy), .notify_idx_out(nidx),
        .notify_kind_out(nkind));
    always @(negedge ref_clk_in) begin
        if (nfy === 1'b1) begin
            ncnt++;
            nlast = {nkind, nidx};
        end
    end
    task automatic chk(input string s, input logic [143:0] e, input logic [143:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cfg(input logic [23:0] v);
        @(negedge ref_clk_in);
        cv = v;
        cfg_wr = 1'b1;
        @(negedge ref_clk_in);
        cfg_wr = 1'b0;
        @(negedge ref_clk_in);
    endtask
    task automatic rtp(input logic [4:0] p);
        @(negedge ref_clk_in);
        ret_idx = p;
        ret = 1'b1;
        @(negedge ref_clk_in);
        ret = 1'b0;
        repeat (3) @(negedge ref_clk_in);
    endtask
    // Polls status (sel 1) or active port (sel 0) of one pair for at most 200 cycles
    task automatic wait_for(input int p, input bit sel, input logic [1:0] v, output int c);
        logic [1:0] g;
        c = 0;
        do begin
            @(negedge ref_clk_in);
            c++;
            g = sel ? pst[2*p-2 +: 2] : pact[2*p-2 +: 2];
        end while (g !== v && c < 200);
        if (g !== v) begin
            chk("wait", v, g);
            complete_run();
        end
    endtask
    function automatic bit delay_ok(input int c);
        return c >= FT * TC && c <= (FT + 2) * TC + 6;
    endfunction
    initial begin
        void'($urandom(32'h6445));
        repeat (10) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        rst_in = 1'b0;
        chk("reset", '0, {pst, pact, nfy});
        cfg({5'h01, 8'h21, 8'h22, 1'b1, 2'h1});
        cfg({5'h02, 8'h41, 8'hd8, 1'b0, 2'h1});
        chk("pairs", 8'h55, {pst[3:0], port_act[143], port_act[24], port_act[1:0]});
        for (i = 3; i <= 18; i++) begin
            n = $urandom % 3;
            cfg({i[4:0], 3'h3 + 3'($urandom % 3), 5'h01 + 5'($urandom % 24),
                3'h3 + 3'($urandom % 3), 5'h01 + 5'($urandom % 24), 1'($urandom), n[1:0]});
            chk("random status", n[1:0], pst[2*i-2 +: 2]);
        end
        snap = pst;
        cfg({5'h00, 8'h21, 8'h22, 1'b1, 2'h2});
        cfg({5'h13, 8'h21, 8'h22, 1'b1, 2'h2});
        chk("bad index", snap, pst);
        drop[0] = 1'b1;
        repeat (8) @(negedge ref_clk_in);
        drop[0] = 1'b0;
        repeat (4) @(negedge ref_clk_in);
        chk("short drop", 2'h0, pact[1:0]);
        drop[0] = 1'b1;
        wait_for(1, 0, 2'h1, n);
        chk("delay", 1'b1, delay_ok(n));
        repeat (2) @(negedge ref_clk_in);
        chk("switch", {2'h2, 32'h1, 6'h01}, {port_act[1:0], ncnt, nlast});
        drop[0] = 1'b0;
        repeat (40) @(negedge ref_clk_in);
        chk("no fallback", 2'h1, pact[1:0]);
        drop[1] = 1'b1;
        wait_for(1, 0, 2'h2, n);
        drop[1] = 1'b0;
        repeat (40) @(negedge ref_clk_in);
        chk("both failed", {2'h2, 32'h1}, {pact[1:0], ncnt});
        cfg({5'h01, 8'h21, 8'h22, 1'b1, 2'h1});
        chk("reinstated", 2'h0, pact[1:0]);
        untest[24] = 1'b1;
        drop[24] = 1'b1;
        repeat (40) @(negedge ref_clk_in);
        chk("untested link", 2'h0, pact[3:2]);
        untest[24] = 1'b0;
        wait_for(2, 0, 2'h1, n);
        repeat (2) @(negedge ref_clk_in);
        chk("silent switch", 32'h1, ncnt);
        drop[24] = 1'b0;
        rtp(5'h02);
        chk("return", {4'h4, 32'h2, 6'h22}, {pst[3:2], pact[3:2], ncnt, nlast});
        off[0] = 1'b1;
        wait_for(1, 1, 2'h2, n);
        drop[0] = 1'b1;
        repeat (40) @(negedge ref_clk_in);
        chk("suspended", 4'h0, {pact[1:0], port_act[1:0]});
        drop[0] = 1'b0;
        rtp(5'h01);
        chk("silent return", 32'h2, ncnt);
        off[0] = 1'b0;
        wait_for(1, 1, 2'h1, n);
        off[1] = 1'b1;
        wait_for(1, 1, 2'h2, n);
        repeat (2) @(negedge ref_clk_in);
        chk("both off", 2'h0, port_act[1:0]);
        off[1] = 1'b0;
        wait_for(1, 1, 2'h1, n);
        repeat (2) @(negedge ref_clk_in);
        chk("normal", 2'h1, port_act[1:0]);
        rtp(5'h01);
        chk("enabled return", {32'h3, 6'h21}, {ncnt, nlast});
        cfg({5'h01, 8'h21, 8'h22, 1'b1, 2'h0});
        drop[0] = 1'b1;
        repeat (40) @(negedge ref_clk_in);
        chk("disabled", 2'h0, pact[1:0]);
        complete_run();
    end
endmodule
